// file: verilog/ldm_scan_ctrl.v
// LED dot-matrix scan controller with AHB-Lite register slave
// Function
// - Run bit starts scanning; zero stops it
// - Size field selects none or one of five geometries
// - Geometry sets how many matrix lines scan
// - Style bit chooses cycle or interrupt scan
// - Lock bit holds common lines as sink ports
// - Locked lines follow GPIO timing when idle
// - First on-time is (value+1) times 16 us
// - Second on-time uses identical scaling
// - Four-bit sink strength, upper bits reserved
`timescale 1ns/1ps
`include "ldm_defines.vh"
module ldm_scan_ctrl (
    input  wire        i_sys_clk,            // System clock, 250 MHz
    input  wire        i_arst_n,             // Async reset, active low
    input  wire        i_hsel,               // AHB slave select
    input  wire [31:0] i_haddr,              // AHB address
    input  wire [1:0]  i_htrans,             // AHB transfer type
    input  wire        i_hwrite,             // AHB write strobe
    input  wire [2:0]  i_hsize,              // AHB size
    input  wire [31:0] i_hwdata,             // AHB write data
    input  wire        i_hready,             // AHB bus ready
    output reg  [31:0] o_hrdata,             // AHB read data
    output reg         o_hreadyout,          // AHB slave ready
    output reg         o_hresp,              // AHB response, always OKAY
    input  wire [8:0]  i_gpio_line_out,      // GPIO drive for locked lines
    output reg  [8:0]  o_matrix_lines,       // Line drive, one hot while scanning
    output reg  [8:0]  o_matrix_lines_oe,    // Line output enables
    output reg         o_common_line_lock,   // Common lines held as sink ports
    output reg  [3:0]  o_sink_strength,      // Sink strength setting
    output reg         o_phase_second,       // High while second on-time phase
    output reg         o_scan_active         // Scanner running
);
    // ----------------------------------------------------------------
    // Registers and state
    // ----------------------------------------------------------------
    reg        scan_run;                     // Run bit
    reg  [7:0] matrix_control;               // Size, style, lock
    reg  [7:0] on_time_first;                // First on-time value
    reg  [7:0] on_time_second;               // Second on-time value
    reg  [3:0] sink_strength;                // Sink strength field
    reg        frame_done;                   // Sticky: one frame completed
    reg        dph_write;                    // Data phase is a write
    reg        dph_read;                     // Data phase is a read
    reg  [7:0] dph_idx;                      // Register index in data phase
    reg  [3:0] line_idx;                     // Current lit line
    reg        phase;                        // 0 first on-time, 1 second
    reg  [8:0] gpio_s1;                      // GPIO sync stage one
    reg  [8:0] gpio_s2;                      // GPIO sync stage two
    reg  [3:0] last_line;                    // Highest participating line
    reg  [31:0] next_rdata;                  // Read mux result
    wire [2:0] size_sel;                     // Matrix size field
    wire       style_cycle;                  // Cycle scan mode
    wire       lock;                         // Common line lock
    wire       scanning;                     // Scanner enabled
    wire       tick;                         // 16 us step
    wire       dwell_done;                   // Current dwell finished
    wire       addr_phase;                   // Valid address phase
    wire       wr_en;                        // Register write this cycle
    wire       wrap;                         // Last line finishing
    wire [7:0] cur_width;                    // On-time for this dwell

    assign size_sel    = matrix_control[`LDM_SIZE_MSB:`LDM_SIZE_LSB];
    assign style_cycle = matrix_control[`LDM_STYLE_BIT];
    assign lock        = matrix_control[`LDM_LOCK_BIT];
    // Size zero means no matrix, so nothing scans even with run set
    assign scanning    = scan_run && (size_sel != 3'h0);
    assign addr_phase  = i_hsel && i_htrans[1] && i_hready;
    assign wr_en       = dph_write;
    // Compare with >= so a size shrunk mid-scan still wraps instead of running off
    assign wrap        = dwell_done && (line_idx >= last_line);
    assign cur_width   = phase ? on_time_second : on_time_first;

    // ----------------------------------------------------------------
    // Geometry to last line
    // ----------------------------------------------------------------
    always @* begin
        case (size_sel)
            3'h1:    last_line = 4'h4;
            3'h2:    last_line = 4'h5;
            3'h3:    last_line = 4'h6;
            3'h4:    last_line = 4'h7;
            3'h5:    last_line = 4'h7;
            3'h6:    last_line = 4'h7;
            3'h7:    last_line = 4'h8;
            default: last_line = 4'h0;
        endcase
    end

    // ----------------------------------------------------------------
    // Time base and dwell timer
    // ----------------------------------------------------------------
    ldm_tick_div #(
        .CYCLES (`LDM_TICK_CYCLES)
    ) u_tick (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_run     (scanning),
        .o_tick    (tick)
    );

    ldm_dwell u_dwell (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_run     (scanning),
        .i_tick    (tick),
        .i_width   (cur_width),
        .o_done    (dwell_done)
    );

    // ----------------------------------------------------------------
    // AHB address phase capture; writes are zero wait state, reads take one
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dph_write <= 1'b0;
            dph_read  <= 1'b0;
            dph_idx   <= 8'h00;
        end else if (i_hready) begin
            dph_write <= addr_phase && i_hwrite;
            dph_read  <= addr_phase && !i_hwrite;
            dph_idx   <= i_haddr[`LDM_ADDR_W-1:2];
        end
    end

    // ----------------------------------------------------------------
    // Register writes; reserved bits are dropped
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            scan_run       <= 1'b0;
            matrix_control <= `LDM_RST_BYTE;
            on_time_first  <= `LDM_RST_BYTE;
            on_time_second <= `LDM_RST_BYTE;
            sink_strength  <= 4'h0;
        end else if (wr_en) begin
            case (dph_idx)
                `LDM_IDX_SCAN_RUN:    scan_run <= i_hwdata[`LDM_RUN_BIT];
                `LDM_IDX_MATRIX_CTRL: matrix_control <= {3'h0, i_hwdata[4:0]};
                `LDM_IDX_ON_TIME_1:   on_time_first <= i_hwdata[7:0];
                `LDM_IDX_ON_TIME_2:   on_time_second <= i_hwdata[7:0];
                `LDM_IDX_SINK:        sink_strength <= i_hwdata[`LDM_SINK_MSB:0];
                default:              scan_run <= scan_run;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read mux; unmapped words read as zero
    // ----------------------------------------------------------------
    always @* begin
        next_rdata = 32'h0000_0000;
        case (dph_idx)
            `LDM_IDX_SCAN_RUN:    next_rdata = {31'h0, scan_run};
            `LDM_IDX_MATRIX_CTRL: next_rdata = {24'h0, matrix_control};
            `LDM_IDX_ON_TIME_1:   next_rdata = {24'h0, on_time_first};
            `LDM_IDX_ON_TIME_2:   next_rdata = {24'h0, on_time_second};
            `LDM_IDX_SINK:        next_rdata = {28'h0, sink_strength};
            `LDM_IDX_STATUS:      next_rdata = {20'h0, frame_done, phase, 4'h0,
                                                line_idx, 1'b0, scanning};
            default:              next_rdata = 32'h0000_0000;
        endcase
    end

    // Reads take one wait state: the mux is loaded after any write landing at
    // the address edge, so a read right behind a write sees the new value
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_hrdata    <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else if (addr_phase && !i_hwrite) begin
            o_hreadyout <= 1'b0;
            o_hresp     <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
            if (dph_read && !o_hreadyout) begin
                o_hrdata <= next_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Scan sequencer; a frame sweeps lines 0 to last_line, then in interrupt scan the status flag sets
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            line_idx   <= 4'h0;
            phase      <= 1'b0;
            frame_done <= 1'b0;
        end else if (!scanning) begin
            line_idx   <= 4'h0;
            phase      <= 1'b0;
            frame_done <= (wr_en && dph_idx == `LDM_IDX_STATUS) ? 1'b0 : frame_done;
        end else begin
            if (dwell_done) begin
                // Each line gets first then second on-time before advancing
                phase <= !phase;
                if (phase) begin
                    line_idx <= (line_idx >= last_line) ? 4'h0 : line_idx + 4'h1;
                end
            end
            // Only interrupt scan flags a finished frame; cycle scan repeats
            // silently. Set wins over a software clear in the same cycle
            if (wrap && phase && !style_cycle) begin
                frame_done <= 1'b1;
            end else if (wr_en && dph_idx == `LDM_IDX_STATUS) begin
                frame_done <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // GPIO input synchroniser for locked-line timing
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gpio_s1 <= 9'h000;
            gpio_s2 <= 9'h000;
        end else begin
            gpio_s1 <= i_gpio_line_out;
            gpio_s2 <= gpio_s1;
        end
    end

    // ----------------------------------------------------------------
    // Line drive outputs
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_matrix_lines     <= 9'h000;
            o_matrix_lines_oe  <= 9'h000;
            o_common_line_lock <= 1'b0;
            o_sink_strength    <= 4'h0;
            o_phase_second     <= 1'b0;
            o_scan_active      <= 1'b0;
        end else begin
            o_common_line_lock <= lock;
            o_sink_strength    <= sink_strength;
            o_phase_second     <= scanning && phase;
            o_scan_active      <= scanning;
            if (scanning) begin
                o_matrix_lines    <= 9'h001 << line_idx;
                o_matrix_lines_oe <= 9'h1FF >> (4'h8 - last_line);
            end else if (lock) begin
                // Locked lines follow GPIO only while all scanning is off
                o_matrix_lines    <= gpio_s2;
                o_matrix_lines_oe <= 9'h1FF;
            end else begin
                o_matrix_lines    <= 9'h000;
                o_matrix_lines_oe <= 9'h000;
            end
        end
    end
endmodule // ldm_scan_ctrl

// file: verilog/ldm_defines.vh
// Register offsets, field positions, reset values and timing counts of the LED matrix scanner
`ifndef LDM_DEFINES_VH
`define LDM_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets (word indices, byte address is index times four; printed offsets kept as indices)
// ----------------------------------------------------------------
`define LDM_IDX_SCAN_RUN      8'hAF
`define LDM_IDX_MATRIX_CTRL   8'hB0
`define LDM_IDX_ON_TIME_1     8'hB1
`define LDM_IDX_ON_TIME_2     8'hB2
`define LDM_IDX_SINK          8'hB3
`define LDM_IDX_STATUS        8'hB4
`define LDM_ADDR_W            10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LDM_RUN_BIT           0
`define LDM_LOCK_BIT          0
`define LDM_STYLE_BIT         1
`define LDM_SIZE_LSB          2
`define LDM_SIZE_MSB          4
`define LDM_SINK_MSB          3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LDM_RST_BYTE          8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LDM_CLK_MHZ           250
`define LDM_TICK_US           16
`define LDM_TICK_CYCLES       (`LDM_TICK_US * `LDM_CLK_MHZ)
`define LDM_LINES             9

`endif

// file: verilog/ldm_tick_div.v
// Divider that makes the 16 us step pulse from the system clock
`timescale 1ns/1ps
module ldm_tick_div #(
    parameter integer CYCLES = 4000          // Cycles per tick
) (
    input  wire i_sys_clk,                   // System clock
    input  wire i_arst_n,                    // Async reset, active low
    input  wire i_run,                       // Counts only while high
    output reg  o_tick                       // One-cycle step pulse
);
    reg [11:0] cnt;                          // Cycle counter

    // ----------------------------------------------------------------
    // Counter; restarts when stopped so the first step is a full one
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt    <= 12'h000;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            cnt    <= 12'h000;
            o_tick <= 1'b0;
        end else if (cnt == CYCLES[11:0] - 12'h001) begin
            cnt    <= 12'h000;
            o_tick <= 1'b1;
        end else begin
            cnt    <= cnt + 12'h001;
            o_tick <= 1'b0;
        end
    end
endmodule // ldm_tick_div

// file: verilog/ldm_dwell.v
// Dwell timer: counts step pulses up to a programmed value plus one
`timescale 1ns/1ps
module ldm_dwell (
    input  wire       i_sys_clk,             // System clock
    input  wire       i_arst_n,              // Async reset, active low
    input  wire       i_run,                 // Timer runs while high
    input  wire       i_tick,                // 16 us step pulse
    input  wire [7:0] i_width,               // Programmed on-time value
    output reg        o_done                 // Pulse when (width+1) steps passed
);
    reg [7:0] steps;                         // Steps elapsed in this dwell

    // ----------------------------------------------------------------
    // Step counter; width is sampled live so a change acts in the current dwell
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            steps  <= 8'h00;
            o_done <= 1'b0;
        end else if (!i_run) begin
            steps  <= 8'h00;
            o_done <= 1'b0;
        end else if (i_tick && steps >= i_width) begin
            steps  <= 8'h00;
            o_done <= 1'b1;
        end else begin
            if (i_tick) begin
                steps <= steps + 8'h01;
            end
            o_done <= 1'b0;
        end
    end
endmodule // ldm_dwell

// file: tb/ldm_scan_ctrl_properties.sv
// Concurrent checks on the ports of the LED matrix scanner
`timescale 1ns/1ps
`include "ldm_defines.vh"
module ldm_scan_ctrl_properties (
    input wire        i_sys_clk,
    input wire        i_arst_n,
    input wire        i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0]  i_htrans,
    input wire        i_hwrite,
    input wire [31:0] i_hwdata,
    input wire        i_hready,
    input wire        o_hreadyout,
    input wire        o_hresp,
    input wire [8:0]  i_gpio_line_out,
    input wire [8:0]  o_matrix_lines,
    input wire [8:0]  o_matrix_lines_oe,
    input wire        o_common_line_lock,
    input wire [3:0]  o_sink_strength,
    input wire        o_scan_active
);
    // ----------------------------------------------------------------
    // Shadow registers and line hold counter
    // ----------------------------------------------------------------
    reg        wr_ph;   // Write data phase pending
    reg [31:0] wr_a;    // Address of that write
    reg [7:0]  sh_run;  // Shadow run register
    reg [7:0]  sh_ctl;  // Shadow control register
    reg [3:0]  sh_snk;  // Shadow sink strength
    reg [8:0]  ln_q;    // Line drive one sample back
    reg [15:0] hold;    // Samples the line pattern has stood; saturates so it never wraps
    function [8:0] span(input [2:0] s);
        case (s)
            3'd0:    span = 9'h000;
            3'd1:    span = 9'h01F;
            3'd2:    span = 9'h03F;
            3'd3:    span = 9'h07F;
            3'd7:    span = 9'h1FF;
            default: span = 9'h0FF;
        endcase
    endfunction
    // Mirror what software wrote, at the edge that ends the data phase
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ph  <= 1'b0;
            wr_a   <= 32'h0;
            sh_run <= 8'h00;
            sh_ctl <= 8'h00;
            sh_snk <= 4'h0;
            ln_q   <= 9'h000;
            hold   <= 16'h0000;
        end else begin
            wr_ph <= i_hsel & i_htrans[1] & i_hready & i_hwrite;
            wr_a  <= i_haddr;
            if (wr_ph && wr_a == {22'h0, `LDM_IDX_SCAN_RUN, 2'b00}) sh_run <= i_hwdata[7:0];
            if (wr_ph && wr_a == {22'h0, `LDM_IDX_MATRIX_CTRL, 2'b00}) sh_ctl <= i_hwdata[7:0];
            if (wr_ph && wr_a == {22'h0, `LDM_IDX_SINK, 2'b00}) sh_snk <= i_hwdata[3:0];
            ln_q <= o_matrix_lines;
            if (o_matrix_lines != ln_q) begin
                hold <= 16'h0001;
            end else if (hold != 16'hFFFF) begin
                hold <= hold + 16'h0001;
            end
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    AST_BUS_OKAY: assert property (!o_hresp)
        else $error("slave answered with an error");
    AST_READ_WAIT: assert property (i_hsel && i_htrans[1] && i_hready && !i_hwrite
        |=> !o_hreadyout ##1 o_hreadyout) else $error("read wait state missing or too long");
    AST_WRITE_NO_WAIT: assert property (i_hsel && i_htrans[1] && i_hready && i_hwrite
        |=> o_hreadyout) else $error("write data phase stalled");
    AST_STOP_ON_ZERO: assert property ($fell(sh_run[0]) |-> ##[0:3] !o_scan_active)
        else $error("scanning went on after run was cleared");
    AST_LOCK_COPY: assert property (sh_ctl[0] == $past(sh_ctl[0], 2)
        |-> o_common_line_lock == sh_ctl[0]) else $error("lock output differs from lock bit");
    AST_SINK_COPY: assert property (sh_snk == $past(sh_snk, 2)
        |-> o_sink_strength == sh_snk) else $error("sink strength output differs from register");
    AST_ONE_LINE: assert property (o_scan_active |-> $onehot0(o_matrix_lines))
        else $error("more than one matrix line lit");
    AST_SPAN_OE: assert property (o_scan_active && sh_ctl[4:2] == $past(sh_ctl[4:2], 2)
        |-> o_matrix_lines_oe == span(sh_ctl[4:2])) else $error("enabled lines wrong for size");
    AST_LIT_IN_SPAN: assert property (o_scan_active |-> (o_matrix_lines & ~o_matrix_lines_oe) == 9'h000)
        else $error("lit line outside the enabled span");
    AST_GPIO_IDLE: assert property ((o_common_line_lock && sh_run[0] == 1'b0 && sh_ctl[4:2] == 3'd0
        && $stable(i_gpio_line_out))[*5] |-> o_matrix_lines == i_gpio_line_out)
        else $error("locked idle lines do not follow GPIO");
    AST_MIN_DWELL: assert property (o_scan_active && o_matrix_lines != ln_q && ln_q != 9'h000
        && o_matrix_lines != 9'h000 |-> hold >= 16'd7990) else $error("line lit shorter than two steps");
endmodule // ldm_scan_ctrl_properties

bind ldm_scan_ctrl ldm_scan_ctrl_properties u_props (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_gpio_line_out(i_gpio_line_out), .o_matrix_lines(o_matrix_lines),
    .o_matrix_lines_oe(o_matrix_lines_oe), .o_common_line_lock(o_common_line_lock),
    .o_sink_strength(o_sink_strength), .o_scan_active(o_scan_active));

// file: tb/ldm_matrix_model.sv
// Behavioural LED matrix that times how long each line pattern stays lit
`timescale 1ns/1ps
module ldm_matrix_model (
    input  wire        i_sys_clk,
    input  wire [8:0]  i_lines,
    output reg  [8:0]  o_cur,
    output reg  [8:0]  o_prev,
    output reg  [31:0] o_hold,
    output reg  [31:0] o_changes
);
    reg [31:0] cnt;  // Cycles the present pattern has been seen
    initial begin
        o_cur = 9'h000;
        o_prev = 9'h000;
        o_hold = 32'h0;
        o_changes = 32'h0;
        cnt = 32'h0;
    end
    // A pattern change closes the previous one and records its lit time
    always @(posedge i_sys_clk) begin
        if (i_lines !== o_cur) begin
            o_prev <= o_cur;
            o_cur <= i_lines;
            o_hold <= cnt;
            cnt <= 32'h1;
            o_changes <= o_changes + 32'h1;
        end else begin
            cnt <= cnt + 32'h1;
        end
    end
endmodule // ldm_matrix_model

// file: tb/led_dot_matrix_scan_controller_tb_top.sv
// Self-checking bench for the LED matrix scanner
`timescale 1ns/1ps
`include "ldm_defines.vh"
module led_dot_matrix_scan_controller_tb_top;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg         hsel = 1'b0;
    reg         hwrite = 1'b0;
    reg  [31:0] haddr = 32'h0;
    reg  [31:0] hwdata = 32'h0;
    reg  [1:0]  htrans = 2'h0;
    reg  [2:0]  hsize = 3'h2;
    reg  [8:0]  gpio = 9'h000;
    wire [31:0] hrdata;
    wire        hready;
    wire        hresp;
    wire        lock;
    wire        phase;
    wire        act;
    wire [8:0]  lines;
    wire [8:0]  oe;
    wire [3:0]  sink;
    wire [8:0]  m_cur;
    wire [8:0]  m_prev;
    wire [31:0] m_hold;
    wire [31:0] m_chg;
    integer     fails = 0;
    integer     checks_done = 0;
    integer     i;
    integer     n;
    reg  [31:0] seed = 32'h56;
    reg  [31:0] v;
    reg  [31:0] base;
    reg  [31:0] exp_q[$];  // Expected read data, oldest first
    reg         rd_ph = 1'b0;
    reg  [31:0] ra[0:4];
    reg  [7:0]  mk[0:4];

    ldm_scan_ctrl DUT (.i_sys_clk(clk), .i_arst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_gpio_line_out(gpio), .o_matrix_lines(lines), .o_matrix_lines_oe(oe),
        .o_common_line_lock(lock), .o_sink_strength(sink), .o_phase_second(phase),
        .o_scan_active(act));
    ldm_matrix_model u_matrix (.i_sys_clk(clk), .i_lines(lines), .o_cur(m_cur),
        .o_prev(m_prev), .o_hold(m_hold), .o_changes(m_chg));

    initial forever #2 clk = ~clk;

    function [31:0] xs;
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        xs = seed;
    endfunction
    function [8:0] span(input [2:0] s);
        case (s)
            3'd0:    span = 9'h000;
            3'd1:    span = 9'h01F;
            3'd2:    span = 9'h03F;
            3'd3:    span = 9'h07F;
            3'd7:    span = 9'h1FF;
            default: span = 9'h0FF;
        endcase
    endfunction
    task check(input [8*12-1:0] nm, input [31:0] seen, input [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("FAIL %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One single AHB transfer; the address phase is held until ready is seen
    task bus(input w, input [31:0] a, input [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= a;
        htrans <= 2'b10;
        @(posedge clk);
        while (!hready) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (!hready) @(posedge clk);
    endtask
    task rd(input [31:0] a, input [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task settle(input integer c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Read data is compared at the edge that closes each read data phase
    always @(posedge clk) begin
        if (rd_ph && hready) check("hrdata", hrdata, exp_q.pop_front());
        if (hready) rd_ph <= hsel & htrans[1] & !hwrite;
    end

    initial begin
        #(4 * 90000);
        fails = fails + 1;
        complete_run;
    end

    initial begin
        ra[0] = {22'h0, `LDM_IDX_SCAN_RUN, 2'b00};
        ra[1] = {22'h0, `LDM_IDX_MATRIX_CTRL, 2'b00};
        ra[2] = {22'h0, `LDM_IDX_ON_TIME_1, 2'b00};
        ra[3] = {22'h0, `LDM_IDX_ON_TIME_2, 2'b00};
        ra[4] = {22'h0, `LDM_IDX_SINK, 2'b00};
        mk[0] = 8'h01;
        mk[1] = 8'h1F;
        mk[2] = 8'hFF;
        mk[3] = 8'hFF;
        mk[4] = 8'h0F;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, then random write and read back through the field masks
        for (i = 0; i < 5; i = i + 1) rd(ra[i], 32'h0);
        settle(1);
        check("active", act, 32'h0);
        check("lock", lock, 32'h0);
        check("sink", sink, 32'h0);
        for (i = 0; i < 5; i = i + 1) begin
            v = xs();
            bus(1'b1, ra[i], v);
            rd(ra[i], {24'h0, v[7:0] & mk[i]});
        end
        bus(1'b1, 32'h100, 32'hFF);
        rd(32'h100, 32'h0);
        bus(1'b1, ra[0], 32'h0);
        bus(1'b1, ra[4], 32'hA5);
        bus(1'b1, ra[1], 32'h1);
        v = xs();
        gpio <= v[8:0];
        settle(8);
        check("sinkout", sink, 32'h5);
        check("lockout", lock, 32'h1);
        check("gpiolines", lines, {23'h0, gpio});
        // Every geometry, alternating the scan style
        for (i = 0; i < 8; i = i + 1) begin
            bus(1'b1, ra[1], {27'h0, i[2:0], i[0], 1'b0});
            bus(1'b1, ra[0], 32'h1);
            settle(4);
            check("span", oe, {23'h0, span(i[2:0])});
            bus(1'b1, ra[0], 32'h0);
            settle(4);
            check("stopped", act, 32'h0);
        end
        // Dwell of (1+1)+(0+1) steps per line, five lines, then wrap
        bus(1'b1, ra[2], 32'h1);
        bus(1'b1, ra[3], 32'h0);
        bus(1'b1, ra[1], 32'h4);
        settle(2);
        base = m_chg;
        bus(1'b1, ra[0], 32'h1);
        for (n = 0; n < 85000 && m_chg - base < 6; n = n + 1) @(posedge clk);
        #1;
        check("wrapfrom", m_prev, 32'h010);
        check("wrapto", m_cur, 32'h001);
        check("dwell", m_hold, 3 * `LDM_TICK_CYCLES);
        // Interrupt scan flags the frame: done, line 0, first phase, running
        rd({22'h0, `LDM_IDX_STATUS, 2'b00}, 32'h0000_0801);
        // Second on-time phase starts two steps after line 0 lit
        settle(2 * `LDM_TICK_CYCLES + 4);
        check("phase2", phase, 32'h1);
        complete_run;
    end
endmodule // led_dot_matrix_scan_controller_tb_top
